// ### hw/lvip_pkg.sv
// Purpose: Constants for the low-voltage control and pending register bank
// Assumes: APB, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
`default_nettype none
package lvip_pkg;
    localparam logic [7:0] LVIP_OFS_PMSC    = 8'h00;
    localparam logic [7:0] LVIP_OFS_PEND    = 8'h04;
    localparam logic [7:0] LVIP_OFS_IRQ_ST  = 8'h08;
    localparam logic [7:0] LVIP_OFS_IRQ_CLR = 8'h0c;
    localparam logic [7:0] LVIP_OFS_IRQ_EN  = 8'h10;
    localparam logic [7:0] LVIP_OFS_SYNC    = 8'h14;
    localparam int LVIP_BIT_FLAG   = 7;
    localparam int LVIP_BIT_ACK    = 6;
    localparam int LVIP_BIT_IE     = 5;
    localparam int LVIP_BIT_RE     = 4;
    localparam int LVIP_BIT_SE     = 3;
    localparam int LVIP_BIT_ME     = 2;
    localparam int LVIP_BIT_BG     = 0;
    localparam int LVIP_NSRC       = 10;
    localparam int LVIP_NEVT       = 2;
    localparam int LVIP_EVT_LV     = 0;
    localparam int LVIP_EVT_PEND   = 1;
    localparam logic [7:0] LVIP_PMSC_RST = 8'h00;
    localparam logic [1:0] LVIP_IRQ_RST  = 2'h0;
endpackage
`default_nettype wire

// ### hw/lvip_sync.sv
// Purpose: Two-flop synchroniser per bit
// Assumes: Asynchronous inputs, single clock
// Notes:   First stage is read only by the second
`default_nettype none
module lvip_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,     // Clock
    input  wire logic         presetn,  // Async reset, low
    input  wire logic [W-1:0] d,        // Async input
    output logic      [W-1:0] q         // Synchronised
);
    logic [W-1:0] meta;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ### hw/lvip_regs.sv
// Purpose: Low-voltage status/control and interrupt pending registers
// Assumes: APB slave, zero wait states, 100 MHz pclk
// Notes:   Peripheral flags and detector arrive asynchronously
//
// What this block does
// [RULE1] Flag sets on detect event only while master enable is set
// [RULE2] Writing one to acknowledge clears flag; zero does nothing
// [RULE3] Acknowledge bit always reads zero
// [RULE4] Interrupt request raised while flag and interrupt enable set
// [RULE5] Chip reset forced while flag, reset enable and master enable
// [RULE6] Stop enable keeps detector running in stop mode
// [RULE7] Master enable turns detector on and gates interrupt, reset and stop enable bits; bandgap bit is not gated
// [RULE8] Master and reset enable accept only the first write after reset
// [RULE9] Bit 0 enables bandgap reference buffer
// [RULE10] Pending 7 is two-wire flag AND enable
// [RULE11] Pending 6 is keypad flag AND enable
// [RULE12] Pending 5 is comparator flag AND enable
// [RULE13] Pending 4 is conversion-done flag AND converter enable
// [RULE14] Pending 3 is OR of three timer/PWM flag-enable pairs
// [RULE15] Pending 2 is second modulo timer overflow AND enable
// [RULE16] Pending 1 is first modulo timer overflow AND enable
// [RULE17] Pending 0 is wakeup timer flag AND enable
// [RULE18] Pending bits read-only, follow source, zero after reset
// [RULE19] Writes to pending register change nothing
`default_nettype none
module lvip_regs
    import lvip_pkg::*;
(
    input  wire logic        pclk,                 // Bus clock
    input  wire logic        presetn,              // Async reset, low
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB enable
    input  wire logic        pwrite,               // APB direction
    input  wire logic [7:0]  paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error
    input  wire logic        low_volt_detect,      // Analog detector out
    input  wire logic        stop_mode,            // Chip in stop
    input  wire logic        twowire_irq_flag,     // Two-wire flag
    input  wire logic        twowire_irq_enable,   // Two-wire enable
    input  wire logic        keypad_flag,          // Keypad flag
    input  wire logic        keypad_irq_enable,    // Keypad enable
    input  wire logic        comparator_flag,      // Comparator flag
    input  wire logic        comparator_irq_enable, // Comparator enable
    input  wire logic        conversion_done_flag, // Converter done
    input  wire logic        converter_irq_enable, // Converter enable
    input  wire logic        timer_overflow_flag,  // Timer/PWM overflow
    input  wire logic        timer_overflow_irq_enable, // Its enable
    input  wire logic        pwm_chan0_flag,       // Channel 0 flag
    input  wire logic        pwm_chan0_irq_enable, // Channel 0 enable
    input  wire logic        pwm_chan1_flag,       // Channel 1 flag
    input  wire logic        pwm_chan1_irq_enable, // Channel 1 enable
    input  wire logic        modulo_timer_two_flag, // Modulo timer two
    input  wire logic        modulo_timer_two_irq_enable, // Its enable
    input  wire logic        modulo_timer_one_flag, // Modulo timer one
    input  wire logic        modulo_timer_one_irq_enable, // Its enable
    input  wire logic        wakeup_timer_flag,    // Wakeup timer flag
    input  wire logic        wakeup_timer_irq_enable, // Its enable
    output logic             low_volt_irq,         // Low-voltage request
    output logic             chip_reset_req,       // Force chip reset
    output logic             detector_on,          // Detector powered
    output logic             bandgap_buffer_on,    // Bandgap buffer on
    output logic             irq                   // Summary interrupt
);
    logic [7:0]               pend;
    logic                     low_volt_flag;
    logic                     low_volt_irq_enable;
    logic                     low_volt_reset_enable;
    logic                     low_volt_stop_enable;
    logic                     low_volt_master_enable;
    logic                     bg_enable;
    logic                     once_done;
    logic [LVIP_NEVT-1:0]     irq_status;
    logic [LVIP_NEVT-1:0]     irq_enable;
    logic                     pend_any_q;
    logic                     lv_q;
    logic [2*LVIP_NSRC+1:0]   raw_in;
    logic [2*LVIP_NSRC+1:0]   syn_in;
    logic [LVIP_NSRC-1:0]     src_flag;
    logic [LVIP_NSRC-1:0]     src_en;
    logic [LVIP_NSRC-1:0]     src_hit;

    // Every pin-level input is resynchronised before use
    assign raw_in = {stop_mode, low_volt_detect,
                     twowire_irq_flag, twowire_irq_enable,
                     keypad_flag, keypad_irq_enable,
                     comparator_flag, comparator_irq_enable,
                     conversion_done_flag, converter_irq_enable,
                     timer_overflow_flag, timer_overflow_irq_enable,
                     pwm_chan0_flag, pwm_chan0_irq_enable,
                     pwm_chan1_flag, pwm_chan1_irq_enable,
                     modulo_timer_two_flag, modulo_timer_two_irq_enable,
                     modulo_timer_one_flag, modulo_timer_one_irq_enable,
                     wakeup_timer_flag, wakeup_timer_irq_enable};

    lvip_sync #(.W(2*LVIP_NSRC+2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw_in),
        .q       (syn_in)
    );

    wire stop_s = syn_in[2*LVIP_NSRC+1];
    wire lvd_s  = syn_in[2*LVIP_NSRC];

    genvar g;
    generate
        for (g = 0; g < LVIP_NSRC; g++) begin : g_src
            assign src_flag[g] = syn_in[2*g+1];
            assign src_en[g]   = syn_in[2*g];
            assign src_hit[g]  = src_flag[g] & src_en[g];
        end
    endgenerate

    // Source order: 9 two-wire ... 0 wakeup timer
    wire [7:0] next_pend = {src_hit[9],                   // [RULE10]
                            src_hit[8],                   // [RULE11]
                            src_hit[7],                   // [RULE12]
                            src_hit[6],                   // [RULE13]
                            |src_hit[5:3],                // [RULE14]
                            src_hit[2],                   // [RULE15]
                            src_hit[1],                   // [RULE16]
                            src_hit[0]};                  // [RULE17]

    // Pending is pure reflection of sources; no write path exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pend <= 8'h00;                      // [RULE18]
        else pend <= next_pend;                           // [RULE19]
    end

    // APB decode
    wire wr_en   = psel & penable & pwrite;
    wire sel_pm  = paddr == LVIP_OFS_PMSC;
    wire sel_pd  = paddr == LVIP_OFS_PEND;
    wire sel_st  = paddr == LVIP_OFS_IRQ_ST;
    wire sel_clr = paddr == LVIP_OFS_IRQ_CLR;
    wire sel_en  = paddr == LVIP_OFS_IRQ_EN;
    wire sel_sy  = paddr == LVIP_OFS_SYNC;
    wire mapped  = sel_pm | sel_pd | sel_st | sel_clr | sel_en | sel_sy;
    wire wr_pm   = wr_en & sel_pm;
    wire ack_wr  = wr_pm & pwdata[LVIP_BIT_ACK];          // [RULE2]
    wire once_wr = wr_pm & ~once_done;                    // [RULE8]

    // Detector active: stop mode only with stop enable
    wire det_act = low_volt_master_enable &               // [RULE7]
                   (~stop_s | low_volt_stop_enable);      // [RULE6]
    wire lv_evt  = det_act & lvd_s;                       // [RULE1]
    wire next_flag = lv_evt | (low_volt_flag & ~ack_wr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_volt_flag <= 1'b0;
        end else begin
            low_volt_flag <= next_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_volt_irq_enable  <= LVIP_PMSC_RST[LVIP_BIT_IE];
            low_volt_stop_enable <= LVIP_PMSC_RST[LVIP_BIT_SE];
            bg_enable            <= LVIP_PMSC_RST[LVIP_BIT_BG];
        end else if (wr_pm) begin
            low_volt_irq_enable  <= pwdata[LVIP_BIT_IE];
            low_volt_stop_enable <= pwdata[LVIP_BIT_SE];
            bg_enable            <= pwdata[LVIP_BIT_BG];  // [RULE9]
        end
    end

    // Write-once pair; later writes silently dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_volt_master_enable <= LVIP_PMSC_RST[LVIP_BIT_ME];
            low_volt_reset_enable  <= LVIP_PMSC_RST[LVIP_BIT_RE];
            once_done              <= 1'b0;
        end else if (once_wr) begin
            low_volt_master_enable <= pwdata[LVIP_BIT_ME]; // [RULE8]
            low_volt_reset_enable  <= pwdata[LVIP_BIT_RE]; // [RULE8]
            once_done              <= 1'b1;
        end
    end

    // Event controller: set wins over clear
    wire pend_any = |pend;
    wire [LVIP_NEVT-1:0] evt = {pend_any & ~pend_any_q,
                                low_volt_flag & ~lv_q};
    wire [LVIP_NEVT-1:0] clr = (wr_en & sel_clr) ?
                               pwdata[LVIP_NEVT-1:0] : '0;
    wire [LVIP_NEVT-1:0] next_status = evt | (irq_status & ~clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= LVIP_IRQ_RST;
            irq_enable <= LVIP_IRQ_RST;
            pend_any_q <= 1'b0;
            lv_q       <= 1'b0;
        end else begin
            irq_status <= next_status;
            pend_any_q <= pend_any;
            lv_q       <= low_volt_flag;
            if (wr_en & sel_en) irq_enable <= pwdata[LVIP_NEVT-1:0];
        end
    end

    // Read mux; acknowledge bit is never stored so reads zero
    wire [7:0] pm_rd = {low_volt_flag, 1'b0,              // [RULE3]
                        low_volt_irq_enable, low_volt_reset_enable,
                        low_volt_stop_enable, low_volt_master_enable,
                        1'b0, bg_enable};
    wire [31:0] rd_mux =
        sel_pm ? {24'h000000, pm_rd} :
        sel_pd ? {24'h000000, pend} :
        sel_st ? {30'h00000000, irq_status} :
        sel_en ? {30'h00000000, irq_enable} :
        sel_sy ? {31'h00000000, once_done} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
        end
    end

    // Outputs registered; requests from next-state, detector and bandgap from current state
    wire next_lv_irq = next_flag & low_volt_irq_enable &
                       low_volt_master_enable;              // [RULE4]
    wire next_rst    = next_flag & low_volt_reset_enable &
                       low_volt_master_enable;              // [RULE5]
    wire next_irq    = |(next_status & irq_enable);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_volt_irq      <= 1'b0;
            chip_reset_req    <= 1'b0;
            detector_on       <= 1'b0;
            bandgap_buffer_on <= 1'b0;
            irq               <= 1'b0;
        end else begin
            low_volt_irq      <= next_lv_irq;
            chip_reset_req    <= next_rst;
            detector_on       <= det_act;                   // [RULE6]
            bandgap_buffer_on <= bg_enable;                 // [RULE9]
            irq               <= next_irq;
        end
    end

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        lv_evt |=> low_volt_flag;
    endproperty
    flag_sets_a: assert property (p_flag_set)               // [RULE1]
        else $error("flag did not set on event");

    flag_gated_a: assert property (                         // [RULE1]
        @(posedge pclk) disable iff (!presetn)
        !low_volt_flag && !low_volt_master_enable |=> !low_volt_flag)
        else $error("flag set without master enable");

    ack_clears_a: assert property (                         // [RULE2]
        @(posedge pclk) disable iff (!presetn)
        ack_wr && !lv_evt |=> !low_volt_flag)
        else $error("acknowledge did not clear flag");

    // Only an acknowledge may drop the flag
    flag_holds_a: assert property (                         // [RULE2]
        @(posedge pclk) disable iff (!presetn)
        low_volt_flag && !ack_wr |=> low_volt_flag)
        else $error("flag dropped without acknowledge");

    ack_zero_a: assert property (                           // [RULE3]
        @(posedge pclk) disable iff (!presetn)
        pready && sel_pm && !pwrite |-> !prdata[LVIP_BIT_ACK])
        else $error("acknowledge read nonzero");

    lv_irq_out_a: assert property (                         // [RULE4]
        @(posedge pclk) disable iff (!presetn)
        low_volt_irq == $past(low_volt_flag) || $past(ack_wr) ||
        $past(lv_evt) || !$past(low_volt_irq_enable))
        else $error("low-voltage request mismatch");

    reset_req_a: assert property (                          // [RULE5]
        @(posedge pclk) disable iff (!presetn)
        chip_reset_req |-> $past(low_volt_master_enable))
        else $error("reset without master enable");

    stop_off_a: assert property (                           // [RULE6]
        @(posedge pclk) disable iff (!presetn)
        stop_s && !low_volt_stop_enable |=> !detector_on)
        else $error("detector ran in stop");

    det_on_a: assert property (                             // [RULE7]
        @(posedge pclk) disable iff (!presetn)
        !low_volt_master_enable |=> !detector_on)
        else $error("detector on without master enable");

    once_hold_a: assert property (                          // [RULE8]
        @(posedge pclk) disable iff (!presetn)
        once_done |=> $stable(low_volt_master_enable)
                   && $stable(low_volt_reset_enable))
        else $error("write-once bit changed");

    bg_follow_a: assert property (                          // [RULE9]
        @(posedge pclk) disable iff (!presetn)
        ##1 bandgap_buffer_on == $past(bg_enable))
        else $error("bandgap buffer does not follow bit");

    pend_twowire_a: assert property (                       // [RULE10]
        @(posedge pclk) disable iff (!presetn)
        ##1 pend[7] == $past(src_flag[9] && src_en[9]))
        else $error("two-wire pending wrong");

    pend_keypad_a: assert property (                        // [RULE11]
        @(posedge pclk) disable iff (!presetn)
        ##1 pend[6] == $past(src_flag[8] && src_en[8]))
        else $error("keypad pending wrong");

    pend_convert_a: assert property (                       // [RULE13]
        @(posedge pclk) disable iff (!presetn)
        ##1 pend[4] == $past(src_flag[6] && src_en[6]))
        else $error("converter pending wrong");

    pend_wakeup_a: assert property (                        // [RULE17]
        @(posedge pclk) disable iff (!presetn)
        ##1 pend[0] == $past(src_flag[0] && src_en[0]))
        else $error("wakeup pending wrong");

    pend_track_a: assert property (                         // [RULE18]
        @(posedge pclk) disable iff (!presetn)
        ##1 pend == $past(next_pend))
        else $error("pending does not follow sources");

    pend_timer_a: assert property (                         // [RULE14]
        @(posedge pclk) disable iff (!presetn)
        ##1 pend[3] == $past(|src_hit[5:3]))
        else $error("timer pending wrong");

    cv_ack: cover property (@(posedge pclk) low_volt_flag ##1 ack_wr);
    cv_rst: cover property (@(posedge pclk) chip_reset_req);
    cv_pend: cover property (@(posedge pclk) pend[7] && pend[0]);
    cv_irq: cover property (@(posedge pclk) irq);
    cv_stop: cover property (@(posedge pclk) stop_s && detector_on);
endmodule
`default_nettype wire

// ### test/lvip_tb.sv
// Purpose: Self-checking bench for the low-voltage and pending registers
// Assumes: Zero-wait APB slave, 100 MHz pclk, 3-cycle source latency
// Notes:   Bench model holds the register state as plain integers
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lvip_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        low_volt_detect;
    logic        stop_mode;
    logic [19:0] src;
    logic        low_volt_irq;
    logic        chip_reset_req;
    logic        detector_on;
    logic        bandgap_buffer_on;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] seed;
    logic [7:0]  exp_pend;
    logic [7:0]  prev_pend;
    int          err_count;
    int          num_checks;
    int          cycles;
    int          me, re, ie, se, bg, flag, armed, st1;

    lvip_regs uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .low_volt_detect(low_volt_detect), .stop_mode(stop_mode),
        .twowire_irq_flag(src[0]), .twowire_irq_enable(src[1]),
        .keypad_flag(src[2]), .keypad_irq_enable(src[3]),
        .comparator_flag(src[4]), .comparator_irq_enable(src[5]),
        .conversion_done_flag(src[6]), .converter_irq_enable(src[7]),
        .timer_overflow_flag(src[8]), .timer_overflow_irq_enable(src[9]),
        .pwm_chan0_flag(src[10]), .pwm_chan0_irq_enable(src[11]),
        .pwm_chan1_flag(src[12]), .pwm_chan1_irq_enable(src[13]),
        .modulo_timer_two_flag(src[14]),
        .modulo_timer_two_irq_enable(src[15]),
        .modulo_timer_one_flag(src[16]),
        .modulo_timer_one_irq_enable(src[17]),
        .wakeup_timer_flag(src[18]), .wakeup_timer_irq_enable(src[19]),
        .low_volt_irq(low_volt_irq), .chip_reset_req(chip_reset_req),
        .detector_on(detector_on), .bandgap_buffer_on(bandgap_buffer_on),
        .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [7:0] pend_of(logic [19:0] s);
        pend_of = {s[0] & s[1], s[2] & s[3], s[4] & s[5], s[6] & s[7],
                   (s[8] & s[9]) | (s[10] & s[11]) | (s[12] & s[13]),
                   s[14] & s[15], s[16] & s[17], s[18] & s[19]};
    endfunction

    function automatic logic [31:0] pmsc_exp();
        pmsc_exp = {24'h000000, flag[0], 1'b0, ie[0], re[0], se[0], me[0],
                    1'b0, bg[0]};
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_pmsc(input logic [31:0] d);
        apb(1'b1, LVIP_OFS_PMSC, d);
        if (armed == 0) begin
            me = d[LVIP_BIT_ME];
            re = d[LVIP_BIT_RE];
            armed = 1;
        end
        ie = d[LVIP_BIT_IE];
        se = d[LVIP_BIT_SE];
        bg = d[LVIP_BIT_BG];
        if (d[LVIP_BIT_ACK] == 1'b1) flag = 0;
        cyc(2);
    endtask

    task automatic detect_pulse();
        low_volt_detect <= 1'b1;
        cyc(5);
        low_volt_detect <= 1'b0;
        if (me != 0) flag = 1;
        cyc(5);
    endtask

    task automatic chk_pmsc();
        apb(1'b0, LVIP_OFS_PMSC, 32'h0);
        check(rdat, pmsc_exp());
        check(rerr, 1'b0);
        check(low_volt_irq, flag & ie & me);
        check(chip_reset_req, flag & re & me);
        check(bandgap_buffer_on, bg);
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        {psel, penable, pwrite, low_volt_detect, stop_mode} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        src = 20'h00000;
        presetn = 1'b0;
        {err_count, num_checks, cycles} = 0;
        {me, re, ie, se, bg, flag, armed, st1} = 0;
        seed = 32'h0000000a;
        prev_pend = 8'h00;
        cyc(20);
        presetn <= 1'b1;
        chk_pmsc();
        apb(1'b0, LVIP_OFS_PEND, 32'h0);
        check(rdat, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check(rerr, 1'b1);
        $display("test reset and unmapped done");

        detect_pulse();
        chk_pmsc();
        wr_pmsc(32'h0000001d);
        chk_pmsc();
        check(detector_on, 1'b1);
        stop_mode <= 1'b1;
        cyc(5);
        check(detector_on, 1'b1);
        wr_pmsc(32'h00000015);
        check(detector_on, 1'b0);
        stop_mode <= 1'b0;
        cyc(5);
        check(detector_on, 1'b1);
        wr_pmsc(32'h00000001);
        chk_pmsc();
        apb(1'b0, LVIP_OFS_SYNC, 32'h0);
        check(rdat[0], 1'b1);
        $display("test control bits done");

        detect_pulse();
        chk_pmsc();
        wr_pmsc(32'h00000021);
        chk_pmsc();
        apb(1'b1, LVIP_OFS_IRQ_EN, 32'h1);
        cyc(3);
        check(irq, 1'b1);
        apb(1'b1, LVIP_OFS_IRQ_EN, 32'h0);
        cyc(3);
        check(irq, 1'b0);
        apb(1'b1, LVIP_OFS_IRQ_ST, 32'h0);
        apb(1'b0, LVIP_OFS_IRQ_ST, 32'h0);
        check(rdat, 32'h1);
        wr_pmsc(32'h00000021);
        chk_pmsc();
        wr_pmsc(32'h00000061);
        chk_pmsc();
        apb(1'b1, LVIP_OFS_IRQ_CLR, 32'h1);
        apb(1'b0, LVIP_OFS_IRQ_ST, 32'h0);
        check(rdat, 32'h0);
        $display("test flag and interrupt done");

        for (int i = 0; i < 40; i++) begin
            for (int k = 0; k < 20; k++) seed = lfsr_next(seed);
            src <= (i == 39) ? 20'h00000 : seed[19:0];
            exp_pend = (i == 39) ? 8'h00 : pend_of(seed[19:0]);
            if (prev_pend == 8'h00 && exp_pend != 8'h00) st1 = 1;
            prev_pend = exp_pend;
            cyc(4);
            apb(1'b0, LVIP_OFS_PEND, 32'h0);
            check(rdat, {24'h0, exp_pend});
            if (i == 5) begin
                apb(1'b1, LVIP_OFS_PEND, 32'hffffffff);
                apb(1'b0, LVIP_OFS_PEND, 32'h0);
                check(rdat, {24'h0, exp_pend});
            end
        end
        apb(1'b0, LVIP_OFS_IRQ_ST, 32'h0);
        check(rdat[1], st1[0]);
        apb(1'b1, LVIP_OFS_IRQ_EN, 32'h2);
        cyc(3);
        check(irq, st1[0]);
        apb(1'b1, LVIP_OFS_IRQ_CLR, 32'h3);
        cyc(3);
        check(irq, 1'b0);
        $display("test pending sources done");
        wrap_up();
    end
endmodule
`default_nettype wire
